// [hw/eeprom_two_wire_bus_slave.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Bus idle only while data and clock lines are both high.
// - Data falling while clock high is a start event.
// - Data rising while clock high is a stop event.
// - Data changes only while clock low; else start/stop.
// - One data bit sampled per clock pulse, after a start.
// - Overlong write keeps last sixteen bytes, oldest overwritten first.
// - Receiver acknowledges each byte on the ninth clock pulse.
// - No acknowledge and data released during internal programming.
// - Acknowledge holds data low through whole ack clock high phase.
// - After master no-ack, device releases data line for stop.
// - Chip-select bits must match all three strap inputs.
// - Write-protect high blocks array writes; low permits them unless supply is low.
// - Low-supply detect disables internal erase and write logic.
// - First byte after start is control: code 1010, selects, rw.
// - Control rw bit one selects read, zero selects write.
module eeprom_two_wire_bus_slave #(
    parameter int unsigned WRITE_CYCLES = eeprom_slave_pkg::WRITE_CYCLE_CYC,
    parameter int unsigned PAGE_BYTES   = eeprom_slave_pkg::PAGE_BYTES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe,
    input  wire logic       chip_select_strap_0,
    input  wire logic       chip_select_strap_1,
    input  wire logic       chip_select_strap_2,
    input  wire logic       write_protect,
    input  wire logic       supply_low,
    output var  logic       busy,
    output var  logic       prog_start,
    output var  logic [7:0] word_addr,
    output var  logic [7:0] read_addr,
    input  wire logic [7:0] read_data,
    output var  logic [7:0] page_data [PAGE_BYTES],
    output var  logic [4:0] page_count
);

    localparam int unsigned PW = $clog2(PAGE_BYTES);

    eeprom_slave_pkg::slave_state_t state_q;
    eeprom_slave_pkg::slave_state_t state_d;

    logic scl;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic sda_rise;
    logic sda_fall;

    line_sync scl_sync (
        .clock (clock),
        .rst   (rst),
        .pin   (scl_in),
        .level (scl),
        .rose  (scl_rise),
        .fell  (scl_fall)
    );

    line_sync sda_sync (
        .clock (clock),
        .rst   (rst),
        .pin   (sda_in),
        .level (sda),
        .rose  (sda_rise),
        .fell  (sda_fall)
    );

    logic [7:0]  shift_q;
    logic [3:0]  bit_q;
    logic        ack_phase_q;
    logic        drive_low_q;
    logic [7:0]  tx_q;
    logic [7:0]  addr_q;
    logic [7:0]  page_q [PAGE_BYTES];
    logic [4:0]  count_q;
    logic        wrote_q;
    logic        busy_q;
    logic        prog_q;
    logic [31:0] timer_q;

    wire bus_idle   = scl && sda;
    wire start_ev   = sda_fall && scl;
    wire stop_ev    = sda_rise && scl;
    wire [7:0] byte_in = {shift_q[6:0], sda};
    wire byte_done  = scl_rise && !ack_phase_q &&
                      (bit_q == eeprom_slave_pkg::BIT_LAST);
    wire code_ok    = byte_in[eeprom_slave_pkg::CODE_MSB:
                              eeprom_slave_pkg::CODE_LSB]
                      == eeprom_slave_pkg::DEVICE_CODE;
    wire sel_ok     = byte_in[eeprom_slave_pkg::SEL_MSB:
                              eeprom_slave_pkg::SEL_LSB]
                      == {chip_select_strap_2, chip_select_strap_1,
                          chip_select_strap_0};
    wire addressed  = code_ok && sel_ok && !busy_q;
    wire is_read    = byte_in[eeprom_slave_pkg::RW_BIT];
    wire may_write  = !write_protect && !supply_low;
    wire ack_fall   = scl_fall && ack_phase_q;
    wire byte_fall  = scl_fall && !ack_phase_q &&
                      (bit_q == eeprom_slave_pkg::BIT_LAST + 4'h1);
    wire [PW-1:0] slot = addr_q[PW-1:0];

    always_comb begin
        state_d = state_q;
        case (state_q)
            eeprom_slave_pkg::ST_IDLE: begin
                state_d = state_q;
            end
            eeprom_slave_pkg::ST_CONTROL: begin
                if (byte_done) begin
                    if (!addressed) begin
                        state_d = eeprom_slave_pkg::ST_IGNORE;
                    end else if (is_read) begin
                        state_d = eeprom_slave_pkg::ST_READ_DATA;
                    end else begin
                        state_d = eeprom_slave_pkg::ST_WORD_ADDR;
                    end
                end
            end
            eeprom_slave_pkg::ST_WORD_ADDR: begin
                if (byte_done) begin
                    state_d = eeprom_slave_pkg::ST_WRITE_DATA;
                end
            end
            eeprom_slave_pkg::ST_WRITE_DATA: begin
                state_d = state_q;
            end
            eeprom_slave_pkg::ST_READ_DATA: begin
                if (byte_done) begin
                    state_d = eeprom_slave_pkg::ST_READ_ACK;
                end
            end
            eeprom_slave_pkg::ST_READ_ACK: begin
                if (scl_rise) begin
                    state_d = sda ? eeprom_slave_pkg::ST_IGNORE
                                  : eeprom_slave_pkg::ST_READ_DATA;
                end
            end
            eeprom_slave_pkg::ST_IGNORE: begin
                state_d = state_q;
            end
            default: begin
                state_d = eeprom_slave_pkg::ST_IDLE;
            end
        endcase
        if (start_ev) begin
            state_d = eeprom_slave_pkg::ST_CONTROL;
        end else if (stop_ev) begin
            state_d = eeprom_slave_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= eeprom_slave_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit counter and shift register; one bit per clock rise
    always_ff @(posedge clock) begin
        if (rst || start_ev || stop_ev) begin
            shift_q     <= 8'h00;
            bit_q       <= 4'h0;
            ack_phase_q <= 1'b0;
        end else if (scl_rise && !ack_phase_q) begin
            shift_q <= byte_in;
            bit_q   <= bit_q + 4'h1;
        end else if (byte_fall) begin
            ack_phase_q <= 1'b1;
            bit_q       <= 4'h0;
        end else if (ack_fall) begin
            ack_phase_q <= 1'b0;
        end
    end

    // Data line driver changes only after a clock fall; start and stop clear it
    always_ff @(posedge clock) begin
        if (rst || start_ev || stop_ev) begin
            drive_low_q <= 1'b0;
            tx_q        <= 8'h00;
        end else if (byte_fall) begin
            drive_low_q <= (state_q != eeprom_slave_pkg::ST_IDLE) &&
                           (state_q != eeprom_slave_pkg::ST_IGNORE) &&
                           (state_q != eeprom_slave_pkg::ST_READ_ACK) &&
                           !busy_q;
        end else if (ack_fall) begin
            if (state_q == eeprom_slave_pkg::ST_READ_DATA) begin
                drive_low_q <= !read_data[7];
                tx_q        <= {read_data[6:0], 1'b1};
            end else begin
                drive_low_q <= 1'b0;
            end
        end else if (scl_fall && !ack_phase_q &&
                     state_q == eeprom_slave_pkg::ST_READ_DATA) begin
            drive_low_q <= !tx_q[7];
            tx_q        <= {tx_q[6:0], 1'b1};
        end
    end

    // Address pointer and sixteen-byte page buffer
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_q  <= 8'h00;
            count_q <= 5'h00;
            wrote_q <= 1'b0;
        end else if (start_ev) begin
            count_q <= 5'h00;
            wrote_q <= 1'b0;
        end else if (byte_done) begin
            case (state_q)
                eeprom_slave_pkg::ST_CONTROL: begin
                    wrote_q <= addressed && !is_read;
                end
                eeprom_slave_pkg::ST_WORD_ADDR: begin
                    addr_q <= byte_in;
                end
                eeprom_slave_pkg::ST_WRITE_DATA: begin
                    page_q[slot] <= byte_in;
                    addr_q[PW-1:0] <= slot + PW'(1);
                    if (count_q != 5'(PAGE_BYTES)) begin
                        count_q <= count_q + 5'h01;
                    end
                end
                eeprom_slave_pkg::ST_READ_DATA: begin
                    addr_q <= addr_q + 8'h01;
                end
                default: begin
                    addr_q <= addr_q;
                end
            endcase
        end
    end

    // Self-timed write cycle started by the stop that closes a write
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_q  <= 1'b0;
            prog_q  <= 1'b0;
            timer_q <= 32'h0000_0000;
        end else begin
            prog_q <= 1'b0;
            if (stop_ev && wrote_q && !busy_q) begin
                busy_q  <= 1'b1;
                prog_q  <= may_write && (count_q != 5'h00);
                timer_q <= WRITE_CYCLES - 1;
            end else if (busy_q) begin
                if (timer_q == 32'h0000_0000) begin
                    busy_q <= 1'b0;
                end else begin
                    timer_q <= timer_q - 32'h0000_0001;
                end
            end
        end
    end

    assign sda_out    = 1'b0;
    assign sda_oe     = drive_low_q && !bus_idle;
    assign busy       = busy_q;
    assign prog_start = prog_q;
    assign word_addr  = addr_q;
    assign read_addr  = addr_q;
    assign page_data  = page_q;
    assign page_count = count_q;

endmodule

`default_nettype wire

// [hw/line_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a level changes once stages two and three agree
module line_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin,
    output var  logic level,
    output var  logic rose,
    output var  logic fell
);

    logic [2:0] sync_q;
    logic       level_q;
    wire        agree = (sync_q[1] == sync_q[2]);

    always_ff @(posedge clock) begin
        if (rst) begin
            sync_q  <= eeprom_slave_pkg::SYNC_RESET;
            level_q <= 1'b1;
        end else begin
            sync_q  <= {sync_q[1:0], pin};
            if (agree) begin
                level_q <= sync_q[2];
            end
        end
    end

    assign level = level_q;
    assign rose  = agree && sync_q[2] && !level_q;
    assign fell  = agree && !sync_q[2] && level_q;

endmodule

`default_nettype wire

// [include/eeprom_slave_pkg.sv]
package eeprom_slave_pkg;

    localparam int unsigned CLOCK_HZ        = 40_000_000;
    localparam int unsigned WRITE_CYCLE_MS  = 10;
    localparam int unsigned WRITE_CYCLE_CYC =
        (WRITE_CYCLE_MS * (CLOCK_HZ / 1000));
    localparam int unsigned PAGE_BYTES      = 16;
    localparam logic [3:0]  DEVICE_CODE     = 4'ha;
    localparam int unsigned CODE_MSB        = 7;
    localparam int unsigned CODE_LSB        = 4;
    localparam int unsigned SEL_MSB         = 3;
    localparam int unsigned SEL_LSB         = 1;
    localparam int unsigned RW_BIT          = 0;
    localparam logic [2:0]  SYNC_RESET      = 3'h7;
    localparam logic [3:0]  BIT_LAST        = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONTROL,
        ST_WORD_ADDR,
        ST_WRITE_DATA,
        ST_READ_DATA,
        ST_READ_ACK,
        ST_IGNORE
    } slave_state_t;

endpackage

// [tb/eeprom_slave_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_checker #(
    parameter int unsigned WRITE_CYCLES = 50
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_oe,
    input wire logic       write_protect,
    input wire logic       supply_low,
    input wire logic       busy,
    input wire logic       prog_start,
    input wire logic [4:0] page_count
);
    logic [31:0] busy_len_q;
    logic [31:0] busy_len_d;
    assign busy_len_d = busy ? busy_len_q + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge clock) begin
        busy_len_q <= rst ? 32'h0000_0000 : busy_len_d;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Low drive seen at the clock rise must last the high phase
    sequence s_low_at_rise;
        $rose(scl_in) && sda_oe;
    endsequence
    sequence s_low_held;
        sda_oe [*4];
    endsequence
    property p_ack_stable;
        s_low_at_rise |-> s_low_held;
    endproperty
    a_ack_stable: assert property (p_ack_stable)
        else $error("data drive dropped during clock high");
    property p_busy_quiet;
        busy |-> !sda_oe;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("data driven while busy");
    property p_busy_len;
        $fell(busy) |-> busy_len_q == WRITE_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    property p_prog_pulse;
        prog_start |=> !prog_start;
    endproperty
    a_prog_pulse: assert property (p_prog_pulse)
        else $error("program pulse too long");
    property p_prog_busy;
        prog_start |-> busy && !$past(busy);
    endproperty
    a_prog_busy: assert property (p_prog_busy)
        else $error("program start outside busy");
    property p_prog_wp;
        prog_start |-> !write_protect;
    endproperty
    a_prog_wp: assert property (p_prog_wp)
        else $error("program while protected");
    property p_prog_supply;
        prog_start |-> !supply_low;
    endproperty
    a_prog_supply: assert property (p_prog_supply)
        else $error("program on low supply");
    property p_page_max;
        page_count <= 5'h10;
    endproperty
    a_page_max: assert property (p_page_max)
        else $error("page count above sixteen");
endmodule
bind eeprom_two_wire_bus_slave eeprom_slave_checker #(
    .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
    .clock(clock), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe),
    .write_protect(write_protect), .supply_low(supply_low),
    .busy(busy), .prog_start(prog_start), .page_count(page_count)
);
`default_nettype wire

// [tb/eeprom_two_wire_bus_slave_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module eeprom_two_wire_bus_slave_tb;
    localparam int WCYC = 400;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] strap = 3'h5;
    logic       write_protect = 1'b0;
    logic       supply_low = 1'b0;
    logic [7:0] read_data = 8'h00;
    logic       scl, sda_low, sda_oe, sda_out, busy, prog_start;
    logic [7:0] read_addr;
    logic [7:0] word_addr;
    logic [7:0] page_data [16];
    logic [4:0] page_count;
    wire logic  sda;
    int         n_fail = 0, num_checks = 0, n_prog = 0, cycles = 0;
    assign sda = !(sda_low | (sda_oe & !sda_out));
    always #12.5 clock = !clock;
    i2c_master_model m (.clock(clock), .sda(sda), .scl(scl),
                        .sda_low(sda_low));
    eeprom_two_wire_bus_slave #(.WRITE_CYCLES(WCYC), .PAGE_BYTES(16)) dut (
        .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_0(strap[0]),
        .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]),
        .write_protect(write_protect), .supply_low(supply_low),
        .busy(busy), .prog_start(prog_start), .word_addr(word_addr),
        .read_addr(read_addr), .read_data(read_data),
        .page_data(page_data), .page_count(page_count));
    always @(posedge clock) begin
        read_data <= read_addr ^ 8'h3c;
        if (prog_start) n_prog <= n_prog + 1;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] ctrl(input logic rw);
        return {eeprom_slave_pkg::DEVICE_CODE, strap, rw};
    endfunction
    task automatic send(input logic [7:0] b, input logic exp);
        logic [7:0] rx;
        logic       ack;
        m.xfer(b, 1'b1, rx, ack);
        check(8'(ack), 8'(exp));
    endtask
    task automatic wait_free();
        for (int i = 0; i < WCYC + 200 && busy === 1'b1; i++)
            @(posedge clock);
        check(8'(busy), 8'h00);
    endtask
    task automatic t_write();
        int p0;
        p0 = n_prog;
        m.start();
        send(ctrl(1'b0), 1'b1);
        send(8'h00, 1'b1);
        for (int i = 0; i < 17; i++) send(8'h40 + 8'(i), 1'b1);
        m.stop();
        repeat (6) @(posedge clock);
        check(8'(busy), 8'h01);
        check(8'(n_prog - p0), 8'h01);
        check(8'(page_count), 8'h10);
        check(page_data[0], 8'h50);
        check(page_data[1], 8'h41);
        check(word_addr, 8'h01);
        m.start();
        send(ctrl(1'b0), 1'b0);
        m.stop();
        wait_free();
    endtask
    task automatic t_refuse();
        for (int k = 0; k < 4; k++) begin
            m.start();
            send(ctrl(1'b0) ^ (8'h02 << k), 1'b0);
            m.stop();
        end
    endtask
    task automatic t_protect();
        int p0;
        for (int k = 0; k < 2; k++) begin
            write_protect <= (k == 0);
            supply_low <= (k == 1);
            p0 = n_prog;
            m.start();
            send(ctrl(1'b0), 1'b1);
            send(8'h20, 1'b1);
            send(8'h77, 1'b1);
            m.stop();
            repeat (6) @(posedge clock);
            check(8'(busy), 8'h01);
            wait_free();
            check(8'(n_prog - p0), 8'h00);
        end
        write_protect <= 1'b0;
        supply_low <= 1'b0;
    endtask
    task automatic t_read();
        logic [7:0] rx;
        logic       ack;
        m.start();
        send(ctrl(1'b0), 1'b1);
        send(8'h05, 1'b1);
        m.start();
        send(ctrl(1'b1), 1'b1);
        m.xfer(8'hff, 1'b1, rx, ack);
        check(rx, 8'h05 ^ 8'h3c);
        check(8'(ack), 8'h00);
        check(word_addr, 8'h06);
        m.stop();
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_write();
        t_refuse();
        t_protect();
        t_read();
        stop_test();
    end
endmodule
`default_nettype wire

// [tb/i2c_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input  wire logic clock,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (2) @(posedge clock);
    endtask
    // Start from idle or as repeated start
    // Extra wait lets the device drop its acknowledge before clock rises
    task automatic start();
        q();
        q();
        sda_low <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b0;
    endtask
    task automatic stop();
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b0;
        q();
    endtask
    // Low 5 clocks, high 3 clocks, data moved only while low
    task automatic clk_bit(input logic b, output logic r);
        @(posedge clock);
        sda_low <= !b;
        repeat (4) @(posedge clock);
        scl <= 1'b1;
        repeat (2) @(posedge clock);
        r = sda;
        @(posedge clock);
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                        output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
        clk_bit(ack_tx, r);
        ack = !r;
    endtask
endmodule
`default_nettype wire
